/* hdl/uart_aux_pkg.sv */
// constants shared by the serial auxiliary logic
package uart_aux_pkg;

	// ==========================================================
	// register indices, byte address is four times the index
	localparam logic [11:0] TX_DATA_IDX  = 12'h224;
	localparam logic [11:0] RX_DATA_IDX  = 12'h226;
	localparam logic [11:0] MODE_IDX     = 12'h220;
	localparam logic [11:0] STATUS_IDX   = 12'h221;
	localparam logic [11:0] BAUD_IDX     = 12'h228;
	localparam int          IDX_LSB      = 2;
	localparam int          IDX_MSB      = 13;

	// ==========================================================
	// mode register fields
	localparam int MODE_ENABLE_BIT   = 15;
	localparam int MODE_PINSEL_HI    = 9;
	localparam int MODE_PINSEL_LO    = 8;
	localparam int MODE_LOOPBACK_BIT = 6;
	localparam int MODE_AUTOBAUD_BIT = 5;
	localparam int MODE_TXDMA_BIT    = 1;
	localparam int MODE_RXDMA_BIT    = 0;

	// ==========================================================
	// status and control register fields
	localparam int STA_RXAVAIL_BIT  = 0;
	localparam int STA_FRAMING_ERR_BIT     = 2;
	localparam int STA_PARITY_ERR_BIT     = 3;
	localparam int STA_RXMODE_HI    = 7;
	localparam int STA_RXMODE_LO    = 6;
	localparam int STA_RXFLAG_BIT   = 8;
	localparam int STA_ERRFLAG_BIT  = 9;
	localparam int STA_TXEN_BIT     = 10;
	localparam int STA_ERRIE_BIT    = 11;
	localparam int STA_TXMODE_LO    = 13;
	localparam int STA_TXMODE_HI    = 15;

	// ==========================================================
	// received word layout
	localparam int RXW_PARITY_ERR_BIT = 11;
	localparam int RXW_FRAMING_ERR_BIT = 10;

	// ==========================================================
	// reset values and codes
	localparam logic [15:0] MODE_RST     = 16'h0000;
	localparam logic [15:0] BAUD_RST     = 16'h0000;
	localparam logic [1:0]  PINSEL_RTS   = 2'h1;
	localparam logic [1:0]  PINSEL_FLOW  = 2'h2;
	localparam logic [1:0]  PINSEL_BCLK  = 2'h3;
	localparam logic [2:0]  HSIZE_WORD   = 3'h2;

	// ==========================================================
	// auto-baud timing: one count per 16 clocks of each of 8 bits
	localparam int          AB_BITS      = 8;
	localparam int          AB_OVERSAMP  = 16;
	localparam int          AB_PRESCALE  = AB_BITS * AB_OVERSAMP;
	localparam logic [6:0]  AB_PRE_LAST  = 7'(AB_PRESCALE - 1);
	localparam logic [2:0]  AB_RISES     = 3'h5;

	typedef enum logic [1:0] {
		AB_IDLE      = 2'b00,
		AB_WAIT_FALL = 2'b01,
		AB_WAIT_RISE = 2'b10,
		AB_MEASURE   = 2'b11
	} ab_state_t;

endpackage

/* hdl/sync2.sv */
// two flip-flop synchroniser for a vector of levels
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
	parameter int              WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* hdl/paired_capture_unit.sv */
// capture unit that measures the auto-baud character
`timescale 1ns/10ps
`default_nettype none
module paired_capture_unit
	import uart_aux_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  wire logic        abort,
	input  wire logic        rx_line,
	output var  logic        busy,
	output var  logic        done,
	output var  logic [15:0] count
);
	ab_state_t  state_q;
	logic       line_q;
	logic [6:0] pre_q;
	logic [2:0] rises_q;
	logic       fall;
	logic       rise;

	assign fall = line_q & ~rx_line;
	assign rise = ~line_q & rx_line;
	assign busy = (state_q != AB_IDLE);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_q <= 1'b1;
		end else begin
			line_q <= rx_line;
		end
	end

	// ==========================================================
	// sequence: fall, first rise, then count to the fifth rise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= AB_IDLE;
			rises_q <= 3'h0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (abort) begin
				state_q <= AB_IDLE;
			end else begin
				unique case (state_q)
					AB_IDLE: begin
						if (start) begin
							state_q <= AB_WAIT_FALL;
						end
					end
					AB_WAIT_FALL: begin
						if (fall) begin
							state_q <= AB_WAIT_RISE;
						end
					end
					AB_WAIT_RISE: begin
						if (rise) begin
							state_q <= AB_MEASURE;
							rises_q <= 3'h1;
						end
					end
					AB_MEASURE: begin
						if (rise) begin
							rises_q <= rises_q + 3'h1;
							if (rises_q == AB_RISES - 3'h1) begin
								state_q <= AB_IDLE;
								done    <= 1'b1;
							end
						end
					end
				endcase
			end
		end
	end

	// ==========================================================
	// accumulated count, cleared when a measurement starts
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= 7'h00;
			count <= 16'h0000;
		end else if (start) begin
			pre_q <= 7'h00;
			count <= 16'h0000;
		end else if (state_q == AB_MEASURE) begin
			pre_q <= (pre_q == AB_PRE_LAST) ? 7'h00 : pre_q + 7'h01;
			if (pre_q == AB_PRE_LAST) begin
				count <= count + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

/* hdl/uart_loopback_autobaud_dma.sv */
// serial auxiliary logic: loopback, auto-baud, dma and register bus
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module uart_loopback_autobaud_dma
	import uart_aux_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output var  logic [31:0] hrdata,
	output var  logic        hreadyout,
	output var  logic        hresp,
	input  wire logic        serial_rx_in,
	output var  logic        serial_tx_out,
	input  wire logic        clear_to_send_in,
	output var  logic        request_to_send_out,
	output var  logic        baud_clock_out,
	input  wire logic        core_tx_line,
	input  wire logic        core_rts,
	input  wire logic        core_bclk,
	input  wire logic        core_tx_done,
	input  wire logic        core_rx_valid,
	input  wire logic [7:0]  core_rx_byte,
	input  wire logic        core_framing_err,
	input  wire logic        core_parity_err,
	output var  logic        rx_line_to_core,
	output var  logic        cts_to_core,
	output var  logic        core_hold_idle,
	output var  logic        capture_unit_busy,
	output var  logic [15:0] baud_divisor,
	output var  logic        module_enable,
	output var  logic        tx_enable,
	output var  logic [15:0] tx_data_word,
	output var  logic        tx_data_load,
	output var  logic        dma_rx_req,
	output var  logic        dma_tx_req,
	output var  logic        rx_irq_flag,
	output var  logic        err_irq_out
);
	logic [15:0] mode_q;
	logic [1:0]  rx_irq_mode_q;
	logic [1:0]  tx_irq_mode_q;
	logic        err_irq_flag_q;
	logic        err_irq_enable_q;
	logic        rx_avail_q;
	logic [15:0] rx_data_word_q;
	logic        tx_active_q;
	logic        wr_q;
	logic [11:0] wr_idx_q;
	logic        wr_ok_q;
	logic [2:0]  sync_q;
	logic        rx_sel;
	logic        ab_busy;
	logic        ab_done;
	logic [15:0] ab_count;
	logic        ab_start;
	logic        acc_ok;
	logic [11:0] acc_idx;
	logic        rd_en;
	logic        wr_mode;
	logic        wr_sta;
	logic        rx_take;
	logic [15:0] sta_view;
	logic [15:0] rd_data;
	logic        loopback_enable;
	logic        autobaud_enable;
	logic [1:0]  pin_enable_sel;
	logic        rx_dma_en;
	logic        tx_dma_en;
	logic        tx_active;

	assign loopback_enable = mode_q[MODE_LOOPBACK_BIT];
	assign autobaud_enable = mode_q[MODE_AUTOBAUD_BIT];
	assign pin_enable_sel  = mode_q[MODE_PINSEL_HI:MODE_PINSEL_LO];
	assign rx_dma_en       = mode_q[MODE_RXDMA_BIT];
	assign tx_dma_en       = mode_q[MODE_TXDMA_BIT];
	assign tx_active       = module_enable & tx_enable;

	// ==========================================================
	// bus address phase decode
	assign acc_ok  = hsel & hready & htrans[1] & (hsize == HSIZE_WORD)
		& (haddr[31:IDX_MSB+1] == '0);
	assign acc_idx = haddr[IDX_MSB:IDX_LSB];
	assign rd_en   = acc_ok & ~hwrite;
	assign wr_mode = wr_q & wr_ok_q & (wr_idx_q == MODE_IDX);
	assign wr_sta  = wr_q & wr_ok_q & (wr_idx_q == STATUS_IDX);
	assign ab_start = wr_mode & hwdata[MODE_AUTOBAUD_BIT] & ~autobaud_enable;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q      <= 1'b0;
			wr_ok_q   <= 1'b0;
			wr_idx_q  <= 12'h000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready) begin
				wr_q     <= hsel & htrans[1] & hwrite;
				wr_ok_q  <= acc_ok;
				wr_idx_q <= acc_idx;
			end
		end
	end

	// ==========================================================
	// loopback and pin routing, rx pin, cts pin and tx loopback through one synchroniser
	sync2 #(
		.WIDTH   (3),
		.RST_VAL (3'h7)
	) u_sync (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.d     ({core_tx_line, clear_to_send_in, serial_rx_in}),
		.q     (sync_q)
	);

	assign rx_sel = loopback_enable ? sync_q[2] : sync_q[0];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_tx_out       <= 1'b1;
			rx_line_to_core     <= 1'b1;
			request_to_send_out <= 1'b1;
			baud_clock_out      <= 1'b0;
			cts_to_core         <= 1'b0;
		end else begin
			serial_tx_out   <= core_tx_line;
			rx_line_to_core <= ab_busy ? 1'b1 : rx_sel;
			request_to_send_out <= (pin_enable_sel == PINSEL_RTS
				|| pin_enable_sel == PINSEL_FLOW) ? core_rts : 1'b1;
			baud_clock_out <= (pin_enable_sel == PINSEL_BCLK)
				? core_bclk : 1'b0;
			if (pin_enable_sel == PINSEL_FLOW) begin
				cts_to_core <= loopback_enable ? core_rts : sync_q[1];
			end else begin
				cts_to_core <= 1'b0;
			end
		end
	end

	// ==========================================================
	// auto-baud measurement
	paired_capture_unit u_capture (
		.clk     (ref_clk),
		.rst_n   (rst_n),
		.start   (ab_start),
		.abort   (~autobaud_enable & ~ab_start),
		.rx_line (rx_sel),
		.busy    (ab_busy),
		.done    (ab_done),
		.count   (ab_count)
	);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_hold_idle    <= 1'b0;
			capture_unit_busy <= 1'b0;
		end else begin
			core_hold_idle    <= ab_busy | ab_start;
			capture_unit_busy <= ab_busy | ab_start;
		end
	end

	// ==========================================================
	// mode and baud divisor registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= MODE_RST;
		end else begin
			if (wr_mode) begin
				mode_q <= hwdata[15:0];
			end
			if (ab_done) begin
				mode_q[MODE_AUTOBAUD_BIT] <= 1'b0;
			end
		end
	end

	assign module_enable = mode_q[MODE_ENABLE_BIT];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_divisor <= BAUD_RST;
		end else if (ab_done) begin
			baud_divisor <= ab_count;
		end else if (wr_q && wr_ok_q && wr_idx_q == BAUD_IDX) begin
			baud_divisor <= hwdata[15:0];
		end
	end

	// ==========================================================
	// status and control register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_irq_mode_q    <= 2'h0;
			tx_irq_mode_q    <= 2'h0;
			tx_enable        <= 1'b0;
			err_irq_enable_q <= 1'b0;
		end else if (wr_sta) begin
			rx_irq_mode_q    <= hwdata[STA_RXMODE_HI:STA_RXMODE_LO];
			tx_irq_mode_q    <= {hwdata[STA_TXMODE_HI],
				hwdata[STA_TXMODE_LO]};
			tx_enable        <= hwdata[STA_TXEN_BIT];
			err_irq_enable_q <= hwdata[STA_ERRIE_BIT];
		end
	end

	// ==========================================================
	// receive word, flags and dma request
	assign rx_take = core_rx_valid & module_enable & ~ab_busy;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_data_word_q <= 16'h0000;
			rx_avail_q     <= 1'b0;
			dma_rx_req     <= 1'b0;
		end else begin
			dma_rx_req <= rx_take & rx_dma_en;
			if (rx_take) begin
				rx_data_word_q <= '0;
				rx_data_word_q[7:0] <= core_rx_byte;
				rx_data_word_q[RXW_PARITY_ERR_BIT] <= core_parity_err;
				rx_data_word_q[RXW_FRAMING_ERR_BIT] <= core_framing_err;
				rx_avail_q <= 1'b1;
			end else if (rd_en && acc_idx == RX_DATA_IDX) begin
				rx_avail_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_irq_flag    <= 1'b0;
			err_irq_flag_q <= 1'b0;
		end else begin
			if (ab_done || (rx_take && !rx_irq_mode_q[1])) begin
				rx_irq_flag <= 1'b1;
			end else if (wr_sta && hwdata[STA_RXFLAG_BIT]) begin
				rx_irq_flag <= 1'b0;
			end
			if (rx_take && (core_framing_err || core_parity_err)) begin
				err_irq_flag_q <= 1'b1;
			end else if (wr_sta && hwdata[STA_ERRFLAG_BIT]) begin
				err_irq_flag_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			err_irq_out <= 1'b0;
		end else begin
			err_irq_out <= err_irq_flag_q & err_irq_enable_q;
		end
	end

	// ==========================================================
	// transmit word and dma request
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_data_word <= 16'h0000;
			tx_data_load <= 1'b0;
		end else begin
			tx_data_load <= wr_q & wr_ok_q & (wr_idx_q == TX_DATA_IDX);
			if (wr_q && wr_ok_q && wr_idx_q == TX_DATA_IDX) begin
				tx_data_word <= hwdata[15:0];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_active_q <= 1'b0;
			dma_tx_req  <= 1'b0;
		end else begin
			tx_active_q <= tx_active;
			dma_tx_req  <= tx_dma_en & tx_active
				& (core_tx_done | ~tx_active_q);
		end
	end

	// ==========================================================
	// read data, registered during the address phase
	always_comb begin
		sta_view = '0;
		sta_view[STA_RXAVAIL_BIT] = rx_avail_q;
		sta_view[STA_FRAMING_ERR_BIT] = ~rx_dma_en
			& rx_data_word_q[RXW_FRAMING_ERR_BIT];
		sta_view[STA_PARITY_ERR_BIT] = ~rx_dma_en
			& rx_data_word_q[RXW_PARITY_ERR_BIT];
		sta_view[STA_RXMODE_HI:STA_RXMODE_LO] = rx_irq_mode_q;
		sta_view[STA_RXFLAG_BIT] = rx_irq_flag;
		sta_view[STA_ERRFLAG_BIT] = err_irq_flag_q;
		sta_view[STA_TXEN_BIT] = tx_enable;
		sta_view[STA_ERRIE_BIT] = err_irq_enable_q;
		sta_view[STA_TXMODE_HI] = tx_irq_mode_q[1];
		sta_view[STA_TXMODE_LO] = tx_irq_mode_q[0];
		unique case (acc_idx)
			MODE_IDX:    rd_data = mode_q;
			STATUS_IDX:  rd_data = sta_view;
			BAUD_IDX:    rd_data = baud_divisor;
			RX_DATA_IDX: rd_data = rx_data_word_q;
			default:     rd_data = 16'h0000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h00000000;
		end else if (hready) begin
			hrdata <= rd_en ? {16'h0000, rd_data} : 32'h00000000;
		end
	end
endmodule
`default_nettype wire

/* tb/uart_aux_props.sv */
// assertions on the ports of the serial auxiliary block
`timescale 1ns/10ps
`default_nettype none
module uart_aux_props (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic serial_tx_out,
	input wire logic core_tx_line,
	input wire logic core_rts,
	input wire logic core_bclk,
	input wire logic core_tx_done,
	input wire logic core_rx_valid,
	input wire logic request_to_send_out,
	input wire logic baud_clock_out,
	input wire logic rx_line_to_core,
	input wire logic core_hold_idle,
	input wire logic capture_unit_busy,
	input wire logic module_enable,
	input wire logic tx_enable,
	input wire logic dma_rx_req,
	input wire logic dma_tx_req
);
	logic both_en;
	assign both_en = module_enable & tx_enable;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// pin routing of tx, rts and baud clock
	property p_tx_pin;
		serial_tx_out == $past(core_tx_line);
	endproperty
	a_tx_pin: assert property (p_tx_pin)
		else $error("tx pin not a copy of core line");
	property p_rts;
		!request_to_send_out |-> !$past(core_rts);
	endproperty
	a_rts: assert property (p_rts)
		else $error("rts pin low without core rts low");
	property p_bclk;
		baud_clock_out |-> $past(core_bclk);
	endproperty
	a_bclk: assert property (p_bclk)
		else $error("baud clock pin high without core clock");
	// ==========================================================
	// auto-baud hold and dma requests
	property p_forced;
		core_hold_idle && $past(core_hold_idle) |-> rx_line_to_core;
	endproperty
	a_forced: assert property (p_forced)
		else $error("receive line not idle during measurement");
	property p_cap;
		capture_unit_busy == core_hold_idle;
	endproperty
	a_cap: assert property (p_cap)
		else $error("capture unit busy differs from hold");
	property p_drop;
		core_hold_idle && $past(core_hold_idle) |-> !dma_rx_req;
	endproperty
	a_drop: assert property (p_drop)
		else $error("receive request during measurement");
	property p_rx_req;
		dma_rx_req |-> $past(core_rx_valid);
	endproperty
	a_rx_req: assert property (p_rx_req)
		else $error("receive request without a character");
	property p_tx_req;
		dma_tx_req |-> $past(core_tx_done)
			|| ($past(both_en) && !$past(both_en, 2));
	endproperty
	a_tx_req: assert property (p_tx_req)
		else $error("transmit request without cause");
endmodule
bind uart_loopback_autobaud_dma uart_aux_props uart_aux_props_i (
	.ref_clk(ref_clk), .rst_n(rst_n), .serial_tx_out(serial_tx_out),
	.core_tx_line(core_tx_line), .core_rts(core_rts),
	.core_bclk(core_bclk), .core_tx_done(core_tx_done),
	.core_rx_valid(core_rx_valid),
	.request_to_send_out(request_to_send_out),
	.baud_clock_out(baud_clock_out), .rx_line_to_core(rx_line_to_core),
	.core_hold_idle(core_hold_idle),
	.capture_unit_busy(capture_unit_busy),
	.module_enable(module_enable), .tx_enable(tx_enable),
	.dma_rx_req(dma_rx_req), .dma_tx_req(dma_tx_req)
);
`default_nettype wire

/* tb/far_side_model.sv */
// remote serial sender and dma controller request counter
`timescale 1ns/10ps
`default_nettype none
module far_side_model #(
	parameter int BIT_CLKS = 160
) (
	input  wire logic       ref_clk,
	input  wire logic       send_go,
	input  wire logic       idle_level,
	input  wire logic       dma_rx_req,
	input  wire logic       dma_tx_req,
	output var  logic       line_out,
	output var  logic [7:0] rx_reqs,
	output var  logic [7:0] tx_reqs
);
	localparam logic [7:0] RX_REQ_CODE = 8'h0b;
	localparam logic [7:0] TX_REQ_CODE = 8'h0c;
	localparam logic [9:0] FRAME = {1'b1, 8'h55, 1'b0};
	logic       sending  = 1'b0;
	logic       bit_q    = 1'b1;
	logic [7:0] rx_cnt_q = 8'h00;
	logic [7:0] tx_cnt_q = 8'h00;
	assign line_out = sending ? bit_q : idle_level;
	assign rx_reqs  = rx_cnt_q;
	assign tx_reqs  = tx_cnt_q;
	// ==========================================================
	// dma channels: one transfer per request
	always @(posedge ref_clk) begin
		if (dma_rx_req === 1'b1)
			rx_cnt_q <= rx_cnt_q + 8'h01;
		if (dma_tx_req === 1'b1)
			tx_cnt_q <= tx_cnt_q + 8'h01;
	end
	// ==========================================================
	// sender: start bit, character lsb first, stop bit
	always @(posedge send_go) begin
		sending <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			bit_q <= FRAME[i];
			repeat (BIT_CLKS) @(posedge ref_clk);
		end
		sending <= 1'b0;
	end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the serial auxiliary block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import uart_aux_pkg::*;
	localparam int BIT_CLKS = 160;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, send_go = 1'b0, pin_lvl = 1'b1;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic core_tx_line = 1'b1, core_rts = 1'b1, core_bclk = 1'b0;
	logic core_tx_done = 1'b0, core_rx_valid = 1'b0, clear_to_send_in = 1'b1;
	logic core_framing_err = 1'b0, core_parity_err = 1'b0;
	logic [7:0] core_rx_byte = 8'h00;
	wire logic [31:0] hrdata;
	wire logic [15:0] baud_divisor, tx_data_word;
	wire logic [7:0] rx_reqs, tx_reqs;
	wire logic hreadyout, hresp, serial_tx_out, request_to_send_out;
	wire logic baud_clock_out, rx_line_to_core, cts_to_core, core_hold_idle;
	wire logic capture_unit_busy, module_enable, tx_enable, tx_data_load;
	wire logic dma_rx_req, dma_tx_req, rx_irq_flag, err_irq_out, rx_pin;
	int n_fail = 0;
	int n_checks = 0;
	uart_loopback_autobaud_dma uart_loopback_autobaud_dma_i (
		.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .serial_rx_in(rx_pin),
		.serial_tx_out(serial_tx_out), .clear_to_send_in(clear_to_send_in),
		.request_to_send_out(request_to_send_out),
		.baud_clock_out(baud_clock_out), .core_tx_line(core_tx_line),
		.core_rts(core_rts), .core_bclk(core_bclk),
		.core_tx_done(core_tx_done), .core_rx_valid(core_rx_valid),
		.core_rx_byte(core_rx_byte), .core_framing_err(core_framing_err),
		.core_parity_err(core_parity_err),
		.rx_line_to_core(rx_line_to_core), .cts_to_core(cts_to_core),
		.core_hold_idle(core_hold_idle),
		.capture_unit_busy(capture_unit_busy),
		.baud_divisor(baud_divisor), .module_enable(module_enable),
		.tx_enable(tx_enable), .tx_data_word(tx_data_word),
		.tx_data_load(tx_data_load), .dma_rx_req(dma_rx_req),
		.dma_tx_req(dma_tx_req), .rx_irq_flag(rx_irq_flag),
		.err_irq_out(err_irq_out)
	);
	far_side_model #(.BIT_CLKS(BIT_CLKS)) far_side_model_i (
		.ref_clk(ref_clk), .send_go(send_go), .idle_level(pin_lvl),
		.dma_rx_req(dma_rx_req), .dma_tx_req(dma_tx_req),
		.line_out(rx_pin), .rx_reqs(rx_reqs), .tx_reqs(tx_reqs)
	);
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	// ==========================================================
	// shared tasks
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkb(input string nm, input logic e, g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wait_rdy();
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 100);
		if (hreadyout !== 1'b1)
			n_fail++;
	endtask
	task automatic bus(input logic wr, input logic [11:0] idx,
			input logic [31:0] wd, output logic [31:0] rd);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= {18'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic wr(input logic [11:0] idx, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, idx, d, x);
	endtask
	task automatic rdc(input string nm, input logic [11:0] idx,
			input logic [31:0] e, m);
		logic [31:0] x;
		bus(1'b0, idx, 32'h0, x);
		chk(nm, e, x & m);
		chkb("hresp", 1'b0, hresp);
		chkb("hready", 1'b1, hreadyout);
	endtask
	task automatic rx_char(input logic [7:0] b, input logic fe, pe);
		@(posedge ref_clk);
		core_rx_valid <= 1'b1;
		core_rx_byte <= b;
		core_framing_err <= fe;
		core_parity_err <= pe;
		@(posedge ref_clk);
		core_rx_valid <= 1'b0;
	endtask
	task automatic tx_done();
		@(posedge ref_clk);
		core_tx_done <= 1'b1;
		@(posedge ref_clk);
		core_tx_done <= 1'b0;
		waitc(2);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_regs();
		rdc("mode", MODE_IDX, {16'h0, MODE_RST}, 32'hffff_ffff);
		rdc("baud", BAUD_IDX, {16'h0, BAUD_RST}, 32'hffff_ffff);
		wr(12'h22f, 32'hffff_ffff);
		rdc("unmapped", 12'h22f, 32'h0, 32'hffff_ffff);
	endtask
	task automatic t_loop();
		wr(MODE_IDX, 32'h8000);
		pin_lvl <= 1'b0;
		waitc(4);
		chkb("pin path", 1'b0, rx_line_to_core);
		wr(MODE_IDX, 32'h8040);
		waitc(4);
		chkb("loop idle", 1'b1, rx_line_to_core);
		@(posedge ref_clk);
		core_tx_line <= 1'b0;
		waitc(2);
		chkb("loop early", 1'b1, rx_line_to_core);
		waitc(1);
		chkb("loop data", 1'b0, rx_line_to_core);
		chkb("tx pin", 1'b0, serial_tx_out);
		@(posedge ref_clk);
		core_tx_line <= 1'b1;
		pin_lvl <= 1'b1;
	endtask
	task automatic t_pins();
		for (int s = 0; s < 4; s++)
			for (int r = 0; r < 2; r++) begin
				wr(MODE_IDX, 32'h8040 | 32'(s) << 8);
				core_rts <= r[0];
				core_bclk <= ~r[0];
				waitc(5);
				chkb("rts", (s == 1 || s == 2) ? r[0] : 1'b1,
					request_to_send_out);
				chkb("cts", (s == 2) ? r[0] : 1'b0, cts_to_core);
				chkb("bclk", (s == 3) & ~r[0], baud_clock_out);
			end
		wr(MODE_IDX, 32'h8200);
		clear_to_send_in <= 1'b0;
		waitc(4);
		chkb("cts pin", 1'b0, cts_to_core);
		wr(MODE_IDX, 32'h8240);
		waitc(2);
		chkb("cts loop", 1'b1, cts_to_core);
	endtask
	task automatic t_rx();
		logic [7:0] p;
		wr(MODE_IDX, 32'h8001);
		wr(STATUS_IDX, 32'h0b00);
		p = rx_reqs;
		rx_char(8'ha5, 1'b1, 1'b0);
		#1;
		chkb("rx req", 1'b1, dma_rx_req);
		waitc(1);
		chkb("rx req end", 1'b0, dma_rx_req);
		chkb("err irq", 1'b1, err_irq_out);
		rdc("rx word", RX_DATA_IDX, 32'h04a5, 32'hffff);
		rdc("sta errs", STATUS_IDX, 32'h0, 32'h000c);
		wr(STATUS_IDX, 32'h0a00);
		waitc(2);
		chkb("err clr", 1'b0, err_irq_out);
		rx_char(8'h3c, 1'b0, 1'b1);
		rx_char(8'h5a, 1'b0, 1'b1);
		waitc(2);
		chk("rx reqs", 32'(p) + 3, 32'(rx_reqs));
		rdc("rx word 2", RX_DATA_IDX, 32'h085a, 32'hffff);
	endtask
	task automatic t_tx();
		logic [7:0] p;
		wr(MODE_IDX, 32'h8002);
		p = tx_reqs;
		wr(STATUS_IDX, 32'h0400);
		waitc(3);
		chk("tx on req", 32'(p) + 1, 32'(tx_reqs));
		chkb("tx en", 1'b1, tx_enable);
		chkb("enable", 1'b1, module_enable);
		tx_done();
		chk("tx done req", 32'(p) + 2, 32'(tx_reqs));
		wr(TX_DATA_IDX, 32'h1234);
		#1;
		chkb("tx load", 1'b1, tx_data_load);
		waitc(2);
		chk("tx word", 32'h1234, {16'h0, tx_data_word});
		chkb("tx load end", 1'b0, tx_data_load);
		wr(MODE_IDX, 32'h8000);
		tx_done();
		chk("no tx dma", 32'(p) + 2, 32'(tx_reqs));
	endtask
	task automatic t_autobaud_enable();
		logic [7:0] p;
		int k;
		wr(BAUD_IDX, 32'h00ff);
		wr(STATUS_IDX, 32'h0180);
		wr(MODE_IDX, 32'h8021);
		waitc(2);
		chkb("hold", 1'b1, core_hold_idle);
		chkb("cap busy", 1'b1, capture_unit_busy);
		p = rx_reqs;
		rx_char(8'h77, 1'b0, 1'b0);
		waitc(2);
		chk("dropped", 32'(p), 32'(rx_reqs));
		@(posedge ref_clk);
		send_go <= 1'b1;
		@(posedge ref_clk);
		send_go <= 1'b0;
		k = 0;
		while (core_hold_idle === 1'b1 && k < 4000) begin
			@(posedge ref_clk);
			k++;
		end
		waitc(2);
		chkb("autobaud_enable end", 1'b0, core_hold_idle);
		chk("divisor", 32'(BIT_CLKS * AB_BITS / AB_PRESCALE),
			{16'h0, baud_divisor});
		chkb("rx flag", 1'b1, rx_irq_flag);
		rdc("mode after", MODE_IDX, 32'h8001, 32'hffff);
		rdc("no rx data", STATUS_IDX, 32'h0, 32'h0001);
	endtask
	// ==========================================================
	// main sequence and watchdog
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_regs();
		t_loop();
		t_pins();
		t_rx();
		t_tx();
		t_autobaud_enable();
		test_done();
	end
	initial begin
		repeat (10000) @(posedge ref_clk);
		n_fail++;
		test_done();
	end
endmodule
`default_nettype wire
